// *** dv/adc_channel_cal_config_regs_tb.sv ***
// Purpose: Self-checking bench for the calibration register bank.
// Assumes: Zero-wait APB slave; byte address is four times the index.
// Notes:   Table rows cover reset and readback; routing tested by hand.
`include "adc_cal_consts.svh"
`default_nettype none
module adc_channel_cal_config_regs_tb;
  import adc_cal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [9:0]  idx;
    logic [15:0] rst, wd, rd;
  } row_type;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0, coeff;
  logic pready, pslverr, er;
  logic signed [9:0] chan1_phase_delay, chan2_phase_delay;
  chan_route_type chan1_route, chan2_route;
  logic [23:0] chan1_offset, chan1_gain;
  logic [15:0] chan2_offset_high_bits;
  logic [3:0] global_dc_filter_coeff;
  int failures = 0, checks = 0;
  row_type rows [7] = '{
    '{`CHAN1_CONFIG_IDX, 16'h0000, 16'hffff, 16'hffc7},
    '{`CHAN1_OFFSET_CAL_HIGH_IDX, 16'h0000, 16'h1234, 16'h1234},
    '{`CHAN1_OFFSET_CAL_LOW_IDX, 16'h0000, 16'habcd, 16'hab00},
    '{`CHAN1_GAIN_CAL_HIGH_IDX, 16'h8000, 16'h5a5a, 16'h5a5a},
    '{`CHAN1_GAIN_CAL_LOW_IDX, 16'h0000, 16'hffff, 16'hff00},
    '{`CHAN2_CONFIG_IDX, 16'h0000, 16'h803a, 16'h8002},
    '{`CHAN2_OFFSET_CAL_HIGH_IDX, 16'h0000, 16'h0f0f, 16'h0f0f}};

  adc_channel_cal_config_regs uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .chan1_phase_delay, .chan1_route, .chan1_offset, .chan1_gain,
    .chan2_phase_delay, .chan2_route, .chan2_offset_high_bits,
    .global_dc_filter_coeff);

  // Free-running 25 MHz clock.
  always #20 pclk = ~pclk;

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic w, input logic [9:0] i,
                     input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits until a routing update has landed.
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #50us;
    failures++;
    complete_run;
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(0, rows[i].idx, 16'h0, 4'h0);
      chk("reset value", rd, {16'h0, rows[i].rst});
    end
    foreach (rows[i]) begin
      apb(1, rows[i].idx, rows[i].wd, 4'hf);
      apb(0, rows[i].idx, 16'h0, 4'h0);
      chk("readback", rd, {16'h0, rows[i].rd});
    end
    settle();
    chk("chan1 phase", {22'h0, chan1_phase_delay}, 32'h3ff);
    chk("chan2 phase", {22'h0, chan2_phase_delay}, 32'h200);
    chk("chan1 offset", {8'h0, chan1_offset}, 32'h1234ab);
    chk("chan1 gain", {8'h0, chan1_gain}, 32'h5a5aff);
    chk("chan2 offset", {16'h0, chan2_offset_high_bits}, 32'h0f0f);
    $display("test register table done");
    // A single byte lane leaves the other lane alone.
    apb(1, `CHAN1_OFFSET_CAL_HIGH_IDX, 16'heeee, 4'h1);
    apb(0, `CHAN1_OFFSET_CAL_HIGH_IDX, 16'h0, 4'h0);
    chk("lane write", rd, 32'h12ee);
    apb(0, 10'h015, 16'h0, 4'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    $display("test lanes and map done");
    // Every select code on both channels.
    for (int c = 0; c < 4; c++) begin
      apb(1, `CHAN1_CONFIG_IDX, 16'(c), 4'hf);
      apb(1, `CHAN2_CONFIG_IDX, 16'(c), 4'hf);
      settle();
      chk("chan1 source", chan1_route[9:6],
          4'h8 >> c);
      chk("chan2 source", chan2_route[9:6], 4'h8 >> c);
    end
    $display("test input select done");
    // Bypass on channel 1 only, global code swept on channel 2.
    apb(1, `CHAN1_CONFIG_IDX, 16'h0004, 4'hf);
    apb(1, `CHAN2_CONFIG_IDX, 16'h0000, 4'hf);
    foreach (rows[k]) begin
      coeff = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : 4'hf;
      apb(1, `GLOBAL_DC_FILTER_IDX, {12'h0, coeff}, 4'hf);
      settle();
      chk("chan1 filter", chan1_route[5:0], 6'h00);
      chk("chan2 filter", chan2_route[5:0], (coeff == 0) ? 6'h00 :
          {1'b1, 5'(coeff) + 5'h01});
      chk("coeff", {28'h0, global_dc_filter_coeff}, 32'(coeff));
      apb(0, `ROUTE_STATUS_IDX, 16'h0, 4'h0);
      chk("route status", rd, {22'h0, coeff != 0, 9'h021});
    end
    // Bypass on channel 2 leaves channel 1 following the global code.
    apb(1, `CHAN1_CONFIG_IDX, 16'h0000, 4'hf);
    apb(1, `CHAN2_CONFIG_IDX, 16'h0004, 4'hf);
    settle();
    chk("chan1 follows", chan1_route[5:0], 6'h30);
    chk("chan2 bypass", chan2_route[5:0], 6'h00);
    $display("test dc filter done");
    // Reset in mid-run restores the defaults.
    @(posedge pclk);
    presetn <= 0;
    settle();
    chk("gain after reset", {8'h0, chan1_gain}, 32'h800000);
    chk("phase after reset", {22'h0, chan1_phase_delay}, 32'h0);
    @(posedge pclk);
    presetn <= 1;
    apb(0, `CHAN1_GAIN_CAL_HIGH_IDX, 16'h0, 4'h0);
    chk("gain word after reset", rd, 32'h8000);
    $display("test second reset done");
    complete_run;
  end
endmodule // adc_channel_cal_config_regs_tb
`default_nettype wire

// *** dv/cal_regs_chk.sv ***
// Purpose: Concurrent checks on the channel calibration register bank.
// Assumes: APB with zero wait states; the word index is paddr[11:2].
// Notes:   Bound to the top module below the checker body.
`include "adc_cal_consts.svh"
`default_nettype none
module cal_regs_chk
  import adc_cal_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input wire logic              pclk,
  input wire logic              presetn,
  // APB side.
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Channel controls.
  input wire logic signed [9:0] chan1_phase_delay,
  input wire chan_route_type    chan1_route,
  input wire chan_route_type    chan2_route,
  input wire logic [23:0]       chan1_gain
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Access phase and word index, shared by the properties.
  logic       acc;
  logic [9:0] idx;
  assign acc = psel && penable;
  assign idx = paddr[11:2];

  cfg_reserved_a: assert property (
    acc && !pwrite && idx == `CHAN1_CONFIG_IDX |-> prdata[5:3] == 3'h0)
    else $error("config reserved bits read nonzero");
  low_reserved_a: assert property (
    acc && !pwrite && (idx == `CHAN1_OFFSET_CAL_LOW_IDX ||
    idx == `CHAN1_GAIN_CAL_LOW_IDX) |-> prdata[7:0] == 8'h00)
    else $error("calibration low byte read nonzero");
  phase_write_a: assert property (
    acc && pwrite && idx == `CHAN1_CONFIG_IDX && pstrb[1:0] == 2'h3
    |=> chan1_phase_delay == $past(pwdata[15:6]))
    else $error("phase delay not taken from write");
  gain_write_a: assert property (
    acc && pwrite && idx == `CHAN1_GAIN_CAL_HIGH_IDX && pstrb == 4'hf
    |=> chan1_gain[23:8] == $past(pwdata[15:0]))
    else $error("gain high bits not taken from write");
  dc_bypass_a: assert property (
    acc && pwrite && idx == `CHAN1_CONFIG_IDX && pstrb[0] && pwdata[2]
    |=> ##1 !chan1_route.filter_on)
    else $error("filter stays on with bypass set");
  short_sel_a: assert property (
    acc && pwrite && idx == `CHAN2_CONFIG_IDX && pstrb[0] &&
    pwdata[1:0] == 2'h1 |=> ##1 chan2_route.short_inputs &&
    !chan2_route.connect_pins)
    else $error("inputs not shorted for select one");
  shift_range_a: assert property (
    chan2_route.filter_on |-> chan2_route.filter_shift inside
    {[5'h02:5'h10]})
    else $error("filter shift out of range");
  mapped_ok_a: assert property (
    acc && (idx == `CHAN1_OFFSET_CAL_HIGH_IDX || idx ==
    `CHAN1_OFFSET_CAL_LOW_IDX || idx == `CHAN2_OFFSET_CAL_HIGH_IDX)
    |-> !pslverr)
    else $error("error flag on a mapped word");

  // Main scenarios that the bench should reach.
  cover property (acc && pslverr);
  cover property (chan1_route.test_neg);
  cover property (chan2_route.filter_on);
endmodule // cal_regs_chk

bind adc_channel_cal_config_regs cal_regs_chk #(.ADDR_W(ADDR_W)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pslverr(pslverr),
  .chan1_phase_delay(chan1_phase_delay), .chan1_route(chan1_route),
  .chan2_route(chan2_route), .chan1_gain(chan1_gain));
`default_nettype wire

// *** rtl/adc_cal_consts.svh ***
// Purpose: Offsets, field positions, reset values and masks of the
//          channel configuration and calibration register bank.
// Assumes: Word indices; the byte address on APB is four times the index.
// Notes:   Definitions only, no logic.
`ifndef ADC_CAL_CONSTS_SVH
`define ADC_CAL_CONSTS_SVH

// Register word indices.
`define CHAN1_CONFIG_IDX          10'h00e
`define CHAN1_OFFSET_CAL_HIGH_IDX 10'h00f
`define CHAN1_OFFSET_CAL_LOW_IDX  10'h010
`define CHAN1_GAIN_CAL_HIGH_IDX   10'h011
`define CHAN1_GAIN_CAL_LOW_IDX    10'h012
`define CHAN2_CONFIG_IDX          10'h013
`define CHAN2_OFFSET_CAL_HIGH_IDX 10'h014
`define GLOBAL_DC_FILTER_IDX      10'h020
`define ROUTE_STATUS_IDX          10'h021

// Field positions inside a configuration word and a calibration low word.
`define PHASE_MSB                 15
`define PHASE_LSB                 6
`define DC_OFF_BIT                2
`define SELECT_MSB                1
`define CAL_LOW_MSB               15
`define CAL_LOW_LSB               8

// Reset values.
`define CONFIG_RESET              16'h0000
`define OFFSET_HIGH_RESET         16'h0000
`define OFFSET_LOW_RESET          16'h0000
`define GAIN_HIGH_RESET           16'h8000
`define GAIN_LOW_RESET            16'h0000
`define COEFF_RESET               4'h0

// Writable bit masks; zero bits are reserved and read as zero.
`define CONFIG_WMASK              16'hffc7
`define FULL_WMASK                16'hffff
`define CAL_LOW_WMASK             16'hff00
`define COEFF_WMASK               16'h000f

// Global coefficient: code zero disables, code n gives 2**-(n+1).
`define COEFF_DISABLED            4'h0
`define COEFF_SHIFT_BASE          5'h01

`endif

// *** rtl/adc_cal_pkg.sv ***
// Purpose: Types shared by the calibration register bank and its decoder.
// Assumes: The constants header is compiled alongside.
// Notes:   Input select encoding is fixed by the converter front end.
`default_nettype none
package adc_cal_pkg;

  // Converter input source selection.
  typedef enum logic [1:0] {
    SEL_EXTERNAL = 2'h0,
    SEL_SHORTED  = 2'h1,
    SEL_TEST_POS = 2'h2,
    SEL_TEST_NEG = 2'h3
  } input_select_type;

  // One channel configuration word as stored.
  typedef struct packed {
    logic signed [9:0] phase_delay;
    logic [2:0]        reserved;
    logic              dc_filter_off;
    input_select_type  input_select;
  } chan_config_type;

  // Front-end controls derived for one channel.
  typedef struct packed {
    logic       connect_pins;
    logic       short_inputs;
    logic       test_pos;
    logic       test_neg;
    logic       filter_on;
    logic [4:0] filter_shift;
  } chan_route_type;

endpackage
`default_nettype wire

// *** rtl/adc_channel_cal_config_regs.sv ***
// Purpose: APB register bank with configuration and calibration words of
//          converter channels 1 and 2, driving their front-end controls.
// Assumes: pclk at 25 MHz, presetn asynchronous active low, APB4 master.
// Notes:   Zero wait states; unmapped addresses answer with pslverr.
// Functional notes
// - channel 1 config holds signed 10-bit phase delay in bits 15:6, reset zero.
// - channel 2 config has its own phase delay, same place and encoding.
// - channel 1 filter-off bit at one bypasses its DC filter always.
// - filter-off bit at zero lets the channel follow the global coefficient.
// - channel 2 has its own filter-off bit acting only on channel 2.
// - select value zero connects the channel's own external input pins.
// - select value one shorts the converter inputs together.
// - select value two applies the positive DC test signal.
// - select value three applies the negative DC test signal.
// - channel 2 select uses the same encoding, default its own pins.
// - offset high word holds offset bits 23:8, reset zero.
// - offset low word holds bits 7:0 in its upper byte, low byte zero.
// - gain high word holds gain bits 23:8, resets to 8000h.
// - gain low word holds bits 7:0 in upper byte, reset zero.
// - channel 1 offset high at index Fh, low at 10h, reset zero.
// - channel 2 offset high at index 14h after channel 2 config.
// - config bits 5:3 are reserved and always read zero.
// - global 4-bit code sets coefficient 1/4 to 1/65536; zero disables.
`include "adc_cal_consts.svh"
`default_nettype none
module adc_channel_cal_config_regs
  import adc_cal_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Channel 1 controls.
  output logic signed [9:0]      chan1_phase_delay,
  output chan_route_type         chan1_route,
  output logic [23:0]            chan1_offset,
  output logic [23:0]            chan1_gain,
  // Channel 2 controls.
  output logic signed [9:0]      chan2_phase_delay,
  output chan_route_type         chan2_route,
  output logic [15:0]            chan2_offset_high_bits,
  // Global DC filter setting.
  output logic [3:0]             global_dc_filter_coeff
);

  // Stored words, reserved bits kept at zero by the write masks.
  chan_config_type chan1_config_reg;
  logic [15:0]     chan1_offset_cal_high_reg;
  logic [15:0]     chan1_offset_cal_low_reg;
  logic [15:0]     chan1_gain_cal_high_reg;
  logic [15:0]     chan1_gain_cal_low_reg;
  chan_config_type chan2_config_reg;
  logic [15:0]     chan2_offset_cal_high_reg;
  logic [3:0]      global_coeff_reg;

  // Bus side state.
  logic [31:0]     prdata_reg;
  logic            pslverr_reg;
  logic [31:0]     read_next;
  logic            mapped_next;
  logic            setup_phase;
  logic            write_commit;
  logic [9:0]      word_index;

  // Per-word write strobes, decoded once so each update block below
  // tests a single enable and no two blocks can disagree on an index.
  logic            chan1_config_we;
  logic            chan1_offset_high_we;
  logic            chan1_offset_low_we;
  logic            chan1_gain_high_we;
  logic            chan1_gain_low_we;
  logic            chan2_config_we;
  logic            chan2_offset_high_we;
  logic            global_coeff_we;

  // Decoded per-channel controls.
  chan_route_type  chan1_route_next;
  chan_route_type  chan2_route_next;

  // Merges a write into a stored word under byte strobes and a mask of
  // writable bits, so reserved positions never pick up written data.
  function automatic logic [15:0] merge_write(
    input logic [15:0] old_word,
    input logic [31:0] wdata,
    input logic [3:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] lane_mask;
    lane_mask = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge_write = (old_word & ~lane_mask) | (wdata[15:0] & lane_mask);
  endfunction

  // Packs one channel's source and filter state into five status bits.
  function automatic logic [4:0] route_bits(input chan_route_type r);
    route_bits = {r.filter_on, r.test_neg, r.test_pos,
                  r.short_inputs, r.connect_pins};
  endfunction

  // True when the access phase commits a write to the given word.
  function automatic logic word_write(input logic       commit,
                                      input logic [9:0] index,
                                      input logic [9:0] target);
    word_write = commit && (index == target);
  endfunction

  // APB phases; the slave never stalls, so every access lasts two cycles.
  assign pready       = 1'b1;
  assign word_index   = paddr[11:2];
  assign setup_phase  = psel && !penable;
  assign write_commit = psel && penable && pready && pwrite && mapped_next;

  // Write strobes; a write to an unmapped or read-only word hits none.
  assign chan1_config_we      = word_write(write_commit, word_index,
                                           `CHAN1_CONFIG_IDX);
  assign chan1_offset_high_we = word_write(write_commit, word_index,
                                           `CHAN1_OFFSET_CAL_HIGH_IDX);
  assign chan1_offset_low_we  = word_write(write_commit, word_index,
                                           `CHAN1_OFFSET_CAL_LOW_IDX);
  assign chan1_gain_high_we   = word_write(write_commit, word_index,
                                           `CHAN1_GAIN_CAL_HIGH_IDX);
  assign chan1_gain_low_we    = word_write(write_commit, word_index,
                                           `CHAN1_GAIN_CAL_LOW_IDX);
  assign chan2_config_we      = word_write(write_commit, word_index,
                                           `CHAN2_CONFIG_IDX);
  assign chan2_offset_high_we = word_write(write_commit, word_index,
                                           `CHAN2_OFFSET_CAL_HIGH_IDX);
  assign global_coeff_we      = word_write(write_commit, word_index,
                                           `GLOBAL_DC_FILTER_IDX);

  // Word map, byte address four times the index:
  //   0x0e channel 1 configuration, 0x0f and 0x10 channel 1 offset,
  //   0x11 and 0x12 channel 1 gain, 0x13 channel 2 configuration,
  //   0x14 channel 2 offset upper bits, 0x20 global coefficient,
  //   0x21 read-only route status of both channels.
  // Any other index is unmapped and answers with pslverr.

  // Read multiplexer and address decode. Reserved bits are zero in the
  // stored words already, so reads return them as zero without masking.
  always_comb begin
    read_next   = 32'h0000_0000;
    mapped_next = 1'b1;
    case (word_index)
      `CHAN1_CONFIG_IDX: begin
        read_next[15:0] = chan1_config_reg;
      end
      `CHAN1_OFFSET_CAL_HIGH_IDX: begin
        read_next[15:0] = chan1_offset_cal_high_reg;
      end
      `CHAN1_OFFSET_CAL_LOW_IDX: begin
        read_next[15:0] = chan1_offset_cal_low_reg;
      end
      `CHAN1_GAIN_CAL_HIGH_IDX: begin
        read_next[15:0] = chan1_gain_cal_high_reg;
      end
      `CHAN1_GAIN_CAL_LOW_IDX: begin
        read_next[15:0] = chan1_gain_cal_low_reg;
      end
      `CHAN2_CONFIG_IDX: begin
        read_next[15:0] = chan2_config_reg;
      end
      `CHAN2_OFFSET_CAL_HIGH_IDX: begin
        read_next[15:0] = chan2_offset_cal_high_reg;
      end
      `GLOBAL_DC_FILTER_IDX: begin
        read_next[3:0] = global_coeff_reg;
      end
      `ROUTE_STATUS_IDX: begin
        read_next[4:0] = route_bits(chan1_route);
        read_next[9:5] = route_bits(chan2_route);
      end
      default: begin
        mapped_next = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle and shown in the
  // access cycle, which keeps prdata off the combinational decode path.
  // A write in the access cycle just before lands at the edge that opens
  // the setup cycle, one edge before the capture, so a read that follows a write at once returns the new value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= pwrite ? 32'h0000_0000 : read_next;
      pslverr_reg <= !mapped_next;
    end else if (!psel) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  // The error flag is gated by the access phase so it never shows in a
  // setup cycle; the registered part alone would linger one cycle.
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  // Storage: each word below resets asynchronously to its default and
  // updates only on its own strobe; the merge keeps reserved bits zero
  // whatever software writes there.

  // Channel 1 configuration word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_config_reg <= `CONFIG_RESET;
    end else if (chan1_config_we) begin
      chan1_config_reg <= merge_write(chan1_config_reg, pwdata, pstrb,
                                      `CONFIG_WMASK);
    end
  end

  // Channel 1 offset, upper sixteen bits of the 24-bit value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_offset_cal_high_reg <= `OFFSET_HIGH_RESET;
    end else if (chan1_offset_high_we) begin
      chan1_offset_cal_high_reg <= merge_write(chan1_offset_cal_high_reg,
                                               pwdata, pstrb,
                                               `FULL_WMASK);
    end
  end

  // Channel 1 offset, low byte held in the upper byte of the word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_offset_cal_low_reg <= `OFFSET_LOW_RESET;
    end else if (chan1_offset_low_we) begin
      chan1_offset_cal_low_reg <= merge_write(chan1_offset_cal_low_reg,
                                              pwdata, pstrb,
                                              `CAL_LOW_WMASK);
    end
  end

  // Channel 1 gain, upper sixteen bits; resets to unity gain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_gain_cal_high_reg <= `GAIN_HIGH_RESET;
    end else if (chan1_gain_high_we) begin
      chan1_gain_cal_high_reg <= merge_write(chan1_gain_cal_high_reg,
                                             pwdata, pstrb,
                                             `FULL_WMASK);
    end
  end

  // Channel 1 gain, low byte held in the upper byte of the word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_gain_cal_low_reg <= `GAIN_LOW_RESET;
    end else if (chan1_gain_low_we) begin
      chan1_gain_cal_low_reg <= merge_write(chan1_gain_cal_low_reg,
                                            pwdata, pstrb,
                                            `CAL_LOW_WMASK);
    end
  end

  // Channel 2 configuration word, independent of channel 1.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan2_config_reg <= `CONFIG_RESET;
    end else if (chan2_config_we) begin
      chan2_config_reg <= merge_write(chan2_config_reg, pwdata, pstrb,
                                      `CONFIG_WMASK);
    end
  end

  // Channel 2 offset, upper sixteen bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan2_offset_cal_high_reg <= `OFFSET_HIGH_RESET;
    end else if (chan2_offset_high_we) begin
      chan2_offset_cal_high_reg <= merge_write(chan2_offset_cal_high_reg,
                                               pwdata, pstrb,
                                               `FULL_WMASK);
    end
  end

  // Global DC filter coefficient shared by both channels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_coeff_reg <= `COEFF_RESET;
    end else if (global_coeff_we) begin
      global_coeff_reg <= 4'(merge_write({12'h000, global_coeff_reg},
                                         pwdata, pstrb,
                                         `COEFF_WMASK));
    end
  end

  // One decoder module serves both channels, so a change to the select
  // encoding always lands on both of them at once.

  // Channel 1 front-end and filter decode.
  chan_route_decode chan1_decode (
    .config_word  (chan1_config_reg),
    .global_coeff (global_coeff_reg),
    .route        (chan1_route_next)
  );

  // Channel 2 decode; it sees only its own word, so its filter-off bit
  // cannot reach channel 1.
  chan_route_decode chan2_decode (
    .config_word  (chan2_config_reg),
    .global_coeff (global_coeff_reg),
    .route        (chan2_route_next)
  );

  // Front-end controls are registered so analog switches see clean
  // levels; they settle one cycle after the word that steers them.
  // The cost is one cycle in which the switches still follow the old
  // word; software should let the front end settle before converting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_route <= '0;
      chan2_route <= '0;
    end else begin
      chan1_route <= chan1_route_next;
      chan2_route <= chan2_route_next;
    end
  end

  // Phase delays pass straight from the stored words as signed counts.
  // The modulator side applies the cycle shift; no sign handling here.
  assign chan1_phase_delay = chan1_config_reg.phase_delay;
  assign chan2_phase_delay = chan2_config_reg.phase_delay;

  // Calibration values assembled from their split words.
  assign chan1_offset = {chan1_offset_cal_high_reg,
                         chan1_offset_cal_low_reg[`CAL_LOW_MSB:
                                                  `CAL_LOW_LSB]};
  assign chan1_gain   = {chan1_gain_cal_high_reg,
                         chan1_gain_cal_low_reg[`CAL_LOW_MSB:
                                                `CAL_LOW_LSB]};
  assign chan2_offset_high_bits = chan2_offset_cal_high_reg;
  assign global_dc_filter_coeff = global_coeff_reg;

endmodule // adc_channel_cal_config_regs
`default_nettype wire

// *** rtl/chan_route_decode.sv ***
// Purpose: Turns one channel configuration word and the global DC filter
//          coefficient into the channel's front-end and filter controls.
// Assumes: Pure combinational logic; the caller registers its inputs.
// Notes:   Used once per channel so both channels decode identically.
`include "adc_cal_consts.svh"
`default_nettype none
module chan_route_decode
  import adc_cal_pkg::*;
(
  // Configuration in.
  input  wire chan_config_type config_word,
  input  wire logic [3:0]      global_coeff,
  // Controls out.
  output chan_route_type       route
);

  // Exactly one source switch closes for any select value.
  always_comb begin
    route = '0;
    case (config_word.input_select)
      SEL_EXTERNAL: route.connect_pins = 1'b1;
      SEL_SHORTED:  route.short_inputs = 1'b1;
      SEL_TEST_POS: route.test_pos     = 1'b1;
      SEL_TEST_NEG: route.test_neg     = 1'b1;
      default:      route.connect_pins = 1'b1;
    endcase
    // The channel bit overrides the global setting only to turn off.
    route.filter_on = !config_word.dc_filter_off &&
                      (global_coeff != `COEFF_DISABLED);
    route.filter_shift = route.filter_on ?
                         ({1'b0, global_coeff} + `COEFF_SHIFT_BASE) :
                         5'h00;
  end

endmodule // chan_route_decode
`default_nettype wire
